// File: inc/adc_cfg_pkg.sv
/*
 * Constants, types and register map of the converter configuration block.
 * Assumes a 32-bit APB master and a computation core that supplies the
 * accumulator and low-pass filter values.
 */
package adc_cfg_pkg;
    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFF_CLK_DIV = 8'h00;
    localparam logic [7:0] OFF_REF_SEL = 8'h04;
    localparam logic [7:0] OFF_PCH_SEL = 8'h08;
    localparam logic [7:0] OFF_PRE_CNT = 8'h0c;
    localparam logic [7:0] OFF_ACQ_CNT = 8'h10;
    localparam logic [7:0] OFF_CAP_SEL = 8'h14;
    localparam logic [7:0] OFF_RPT_THR = 8'h18;
    localparam logic [7:0] OFF_RPT_CNT = 8'h1c;
    localparam logic [7:0] OFF_FLT_HI = 8'h20;
    localparam logic [7:0] OFF_CONTROL = 8'h24;
    localparam logic [7:0] OFF_STATUS = 8'h28;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int NREF_BIT = 4;
    localparam int CTL_GO_BIT = 0;
    localparam int CTL_DBL_BIT = 1;
    localparam int CTL_MODE_LSB = 4;
    localparam int CTL_SHIFT_LSB = 8;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam logic [8:0] CONV_CLOCKS = 9'h00b;
    localparam logic [8:0] ACQ_ZERO_WITH_PRE = 9'h100;

    // ****************************************************************
    // Codes
    // ****************************************************************
    localparam logic [1:0] PREF_VDD = 2'h0;
    localparam logic [1:0] PREF_EXT = 2'h2;
    localparam logic [1:0] PREF_FVR = 2'h3;
    localparam logic [5:0] CH_FVR = 6'h3f;
    localparam logic [5:0] CH_DAC = 6'h3e;
    localparam logic [5:0] CH_TEMP = 6'h3d;
    localparam logic [5:0] CH_GND = 6'h3c;
    localparam logic [5:0] CH_FIRST_NONE = 6'h18;

    typedef enum logic [2:0] {
        MODE_BASIC = 3'h0,
        MODE_ACCUM = 3'h1,
        MODE_AVG = 3'h2,
        MODE_BURST = 3'h3,
        MODE_LPF = 3'h4
    } comp_mode_e;

    typedef struct packed {
        logic neg_ref_ext;
        logic pos_ref_vdd;
        logic pos_ref_ext;
        logic pos_ref_fvr;
        logic ch_port_en;
        logic [4:0] ch_port;
        logic ch_fvr;
        logic ch_dac;
        logic ch_temp;
        logic ch_gnd;
        logic [4:0] cap_pf;
    } analog_ctrl_s;

    typedef struct packed {
        logic precharge;
        logic acquire;
        logic convert;
        logic second;
    } phase_ctrl_s;
endpackage

// File: rtl/adc_timing_input_config.sv
/*
 * Configuration registers, conversion clock divider and phase sequencer
 * of a successive-approximation converter, reached over APB.
 * Assumes the analog multiplexer, references and converter core follow
 * the registered control outputs, and that the computation core supplies
 * the accumulator and low-pass filter values as plain inputs.
 */
// The address map and the APB interface to the registers were chosen for this implementation.
// Overview of operation
// - Conversion clock is system clock divided by two times (select plus one).
// - Negative reference uses external pin when its select bit is one, else ground.
// - Positive reference: 11 fixed reference, 10 external pin, 00 supply, 01 reserved.
// - Channel codes select fixed ref, DAC, temperature, ground, nothing, or port pins.
// - Precharge lasts programmed conversion clocks; zero omits the precharge phase.
// - Acquisition lasts programmed clocks; zero without precharge omits it.
// - With precharge enabled, acquisition count zero means 256 conversion clocks.
// - Extra sample capacitance equals the select value in picofarads; zero adds none.
// - Repeat threshold is compared with repeat counter for averaging, burst and filter modes.
// - Repeat counter counts triggers; threshold check only once threshold is reached.
// - Unimplemented register bits ignore writes and read as zero.
// - Filter output high byte is read-only, holds bits 15:8, undefined after reset.
// - Filter output is shifted accumulator, or low-pass output in filter mode.
// - Stage status: 000 idle, 001-011 first stages, 101-111 second stages.
module adc_timing_input_config
    import adc_cfg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] accumulator_value,
    input wire logic [15:0] lowpass_value,
    output analog_ctrl_s analog_ctrl,
    output phase_ctrl_s phase_ctrl,
    output logic conv_clk_tick,
    output logic threshold_check
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PRE,
        ST_ACQ,
        ST_CONV
    } stage_e;

    logic [5:0] conv_clock_div_sel_q;
    logic neg_ref_sel_q;
    logic [1:0] pos_ref_sel_q;
    logic [5:0] pos_channel_sel_q;
    logic [7:0] precharge_count_q;
    logic [7:0] acquisition_count_q;
    logic [4:0] extra_cap_sel_q;
    logic [7:0] repeat_threshold_value_q;
    logic [7:0] repeat_count_value_q;
    logic [7:0] filter_result_hi_q;
    logic go_q;
    logic double_q;
    logic [2:0] mode_q;
    logic [2:0] result_shift_amount_q;
    logic [6:0] div_cnt_q;
    logic tick_q;
    stage_e stage_q;
    logic second_q;
    logic [8:0] phase_cnt_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic wr_en;
    logic [7:0] addr;
    logic conv_done;
    logic last_tick;
    logic [7:0] count_next;
    logic [15:0] shifted;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [8:0] acq_clocks(input logic [7:0] pre, input logic [7:0] acq);
        if (pre != 8'h00 && acq == 8'h00) begin
            acq_clocks = ACQ_ZERO_WITH_PRE;
        end else begin
            acq_clocks = {1'b0, acq};
        end
    endfunction

    function automatic logic mode_uses_repeat(input logic [2:0] m);
        mode_uses_repeat = (m == MODE_AVG) || (m == MODE_BURST) || (m == MODE_LPF);
    endfunction

    assign addr = paddr[7:0];
    assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q;
    assign last_tick = tick_q && (phase_cnt_q == 9'h001);
    assign conv_done = last_tick && (stage_q == ST_CONV) && (second_q || !double_q);
    assign count_next = (repeat_count_value_q == 8'hff) ? 8'hff : repeat_count_value_q + 8'h01;
    assign shifted = accumulator_value >> result_shift_amount_q;

    // ****************************************************************
    // APB slave, one access cycle, no wait states
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable) begin
            pready_q <= 1'b1;
            pslverr_q <= (addr > OFF_STATUS) || (addr[1:0] != 2'h0) || (paddr[31:8] != 24'h0);
            prdata_q <= 32'h0000_0000;
            case (addr)
                OFF_CLK_DIV: prdata_q[5:0] <= conv_clock_div_sel_q;
                OFF_REF_SEL: prdata_q[4:0] <= {neg_ref_sel_q, 2'h0, pos_ref_sel_q};
                OFF_PCH_SEL: prdata_q[5:0] <= pos_channel_sel_q;
                OFF_PRE_CNT: prdata_q[7:0] <= precharge_count_q;
                OFF_ACQ_CNT: prdata_q[7:0] <= acquisition_count_q;
                OFF_CAP_SEL: prdata_q[4:0] <= extra_cap_sel_q;
                OFF_RPT_THR: prdata_q[7:0] <= repeat_threshold_value_q;
                OFF_RPT_CNT: prdata_q[7:0] <= repeat_count_value_q;
                OFF_FLT_HI: prdata_q[7:0] <= filter_result_hi_q;
                OFF_CONTROL: prdata_q[10:0] <= {result_shift_amount_q, 1'b0, mode_q,
                    2'h0, double_q, go_q};
                OFF_STATUS: prdata_q[2:0] <= {second_q & |stage_q, stage_q};
                default: prdata_q <= 32'h0000_0000;
            endcase
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_clock_div_sel_q <= CFG_RESET[5:0];
            neg_ref_sel_q <= 1'b0;
            pos_ref_sel_q <= CFG_RESET[1:0];
            pos_channel_sel_q <= CFG_RESET[5:0];
            precharge_count_q <= CFG_RESET;
            acquisition_count_q <= CFG_RESET;
            extra_cap_sel_q <= CFG_RESET[4:0];
            repeat_threshold_value_q <= CFG_RESET;
            double_q <= 1'b0;
            mode_q <= MODE_BASIC;
            result_shift_amount_q <= 3'h0;
        end else if (wr_en) begin
            case (addr)
                OFF_CLK_DIV: conv_clock_div_sel_q <= pwdata[5:0];
                OFF_REF_SEL: begin
                    neg_ref_sel_q <= pwdata[NREF_BIT];
                    pos_ref_sel_q <= pwdata[1:0];
                end
                OFF_PCH_SEL: pos_channel_sel_q <= pwdata[5:0];
                OFF_PRE_CNT: precharge_count_q <= pwdata[7:0];
                OFF_ACQ_CNT: acquisition_count_q <= pwdata[7:0];
                OFF_CAP_SEL: extra_cap_sel_q <= pwdata[4:0];
                OFF_RPT_THR: repeat_threshold_value_q <= pwdata[7:0];
                OFF_CONTROL: begin
                    double_q <= pwdata[CTL_DBL_BIT];
                    mode_q <= pwdata[CTL_MODE_LSB +: 3];
                    result_shift_amount_q <= pwdata[CTL_SHIFT_LSB +: 3];
                end
                default: ;
            endcase
        end
    end

    // Software starts a conversion; hardware ends it. A write of one in the
    // cycle the conversion finishes wins, so the new trigger is not lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            go_q <= 1'b0;
        end else if (wr_en && addr == OFF_CONTROL && pwdata[CTL_GO_BIT]) begin
            go_q <= 1'b1;
        end else if (conv_done) begin
            go_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Repeat counter and filter output
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            repeat_count_value_q <= 8'h00;
            threshold_check <= 1'b0;
        end else begin
            threshold_check <= 1'b0;
            if (conv_done) begin
                repeat_count_value_q <= count_next;
                threshold_check <= mode_uses_repeat(mode_q)
                    && (count_next >= repeat_threshold_value_q);
            end else if (wr_en && addr == OFF_RPT_CNT) begin
                repeat_count_value_q <= pwdata[7:0];
            end
        end
    end

    // Left without reset on purpose: its value is undefined until the first result.
    always_ff @(posedge pclk) begin
        if (conv_done && mode_q != MODE_BASIC) begin
            filter_result_hi_q <= (mode_q == MODE_LPF) ? lowpass_value[15:8]
                                                       : shifted[15:8];
        end
    end

    // ****************************************************************
    // Conversion clock divider
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_q <= 7'h00;
            tick_q <= 1'b0;
        end else if (div_cnt_q >= {conv_clock_div_sel_q, 1'b1}) begin
            div_cnt_q <= 7'h00;
            tick_q <= 1'b1;
        end else begin
            div_cnt_q <= div_cnt_q + 7'h01;
            tick_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Phase sequencer
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_q <= ST_IDLE;
            second_q <= 1'b0;
            phase_cnt_q <= 9'h000;
        end else if (tick_q) begin
            case (stage_q)
                ST_IDLE: begin
                    if (go_q) begin
                        if (precharge_count_q != 8'h00) begin
                            stage_q <= ST_PRE;
                            phase_cnt_q <= {1'b0, precharge_count_q};
                        end else if (acquisition_count_q != 8'h00) begin
                            stage_q <= ST_ACQ;
                            phase_cnt_q <= {1'b0, acquisition_count_q};
                        end else begin
                            stage_q <= ST_CONV;
                            phase_cnt_q <= CONV_CLOCKS;
                        end
                    end
                end
                ST_PRE: begin
                    if (phase_cnt_q == 9'h001) begin
                        stage_q <= ST_ACQ;
                        phase_cnt_q <= acq_clocks(precharge_count_q, acquisition_count_q);
                    end else begin
                        phase_cnt_q <= phase_cnt_q - 9'h001;
                    end
                end
                ST_ACQ: begin
                    if (phase_cnt_q == 9'h001) begin
                        stage_q <= ST_CONV;
                        phase_cnt_q <= CONV_CLOCKS;
                    end else begin
                        phase_cnt_q <= phase_cnt_q - 9'h001;
                    end
                end
                ST_CONV: begin
                    if (phase_cnt_q == 9'h001) begin
                        // The second pass reruns the same phases from the idle decision.
                        stage_q <= ST_IDLE;
                        second_q <= double_q && !second_q;
                    end else begin
                        phase_cnt_q <= phase_cnt_q - 9'h001;
                    end
                end
                default: stage_q <= ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Registered analog controls
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_ctrl <= '0;
            phase_ctrl <= '0;
            conv_clk_tick <= 1'b0;
        end else begin
            analog_ctrl.neg_ref_ext <= neg_ref_sel_q;
            analog_ctrl.pos_ref_vdd <= (pos_ref_sel_q == PREF_VDD);
            analog_ctrl.pos_ref_ext <= (pos_ref_sel_q == PREF_EXT);
            analog_ctrl.pos_ref_fvr <= (pos_ref_sel_q == PREF_FVR);
            analog_ctrl.ch_port_en <= (pos_channel_sel_q < CH_FIRST_NONE);
            analog_ctrl.ch_port <= pos_channel_sel_q[4:0];
            analog_ctrl.ch_fvr <= (pos_channel_sel_q == CH_FVR);
            analog_ctrl.ch_dac <= (pos_channel_sel_q == CH_DAC);
            analog_ctrl.ch_temp <= (pos_channel_sel_q == CH_TEMP);
            analog_ctrl.ch_gnd <= (pos_channel_sel_q == CH_GND);
            analog_ctrl.cap_pf <= extra_cap_sel_q;
            phase_ctrl.precharge <= (stage_q == ST_PRE);
            phase_ctrl.acquire <= (stage_q == ST_ACQ);
            phase_ctrl.convert <= (stage_q == ST_CONV);
            phase_ctrl.second <= second_q;
            conv_clk_tick <= tick_q;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

endmodule

// File: bench/adc_cfg_asserts.sv
/* Port checker of the converter configuration block.
   Assumes it is bound to adc_timing_input_config and sees only its ports. */
module adc_cfg_asserts
    import adc_cfg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] accumulator_value,
    input wire logic [15:0] lowpass_value,
    input wire analog_ctrl_s analog_ctrl,
    input wire phase_ctrl_s phase_ctrl,
    input wire logic conv_clk_tick,
    input wire logic threshold_check
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wr(logic [7:0] a);
        psel && penable && pwrite && paddr == {24'h0, a};
    endsequence
    logic [5:0] div_q;
    logic [8:0] gap_q;
    logic [1:0] dirty_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) div_q <= 6'h00;
        else if (psel && penable && pwrite && paddr == 32'h0) div_q <= pwdata[5:0];
    end
    // Two tick intervals are skipped after a divider write, as a count may straddle it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q <= 9'h000;
            dirty_q <= 2'h2;
        end else begin
            gap_q <= conv_clk_tick ? 9'h000 : gap_q + 9'h001;
            if (psel && penable && pwrite && paddr == 32'h0) dirty_q <= 2'h2;
            else if (conv_clk_tick && dirty_q != 2'h0) dirty_q <= dirty_q - 2'h1;
        end
    end
    ready_after_setup_a: assert property (s_setup |=> pready)
        else $error("pready missing after setup");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    error_decode_a: assert property (s_setup |=> pslverr ==
        ($past(paddr[1:0]) != 2'h0 || $past(paddr) > 32'h28)) else $error("pslverr wrong");
    tick_period_a: assert property (conv_clk_tick && dirty_q == 2'h0 |->
        int'(gap_q) + 1 == 2 * (int'(div_q) + 1)) else $error("tick period wrong");
    neg_ref_a: assert property (s_wr(OFF_REF_SEL) |-> ##2
        analog_ctrl.neg_ref_ext == $past(pwdata[NREF_BIT], 2)) else $error("neg ref wrong");
    pos_ref_a: assert property (s_wr(OFF_REF_SEL) |-> ##2
        {analog_ctrl.pos_ref_vdd, analog_ctrl.pos_ref_ext, analog_ctrl.pos_ref_fvr} ==
        {$past(pwdata[1:0], 2) == PREF_VDD, $past(pwdata[1:0], 2) == PREF_EXT,
        $past(pwdata[1:0], 2) == PREF_FVR}) else $error("pos ref wrong");
    channel_decode_a: assert property (s_wr(OFF_PCH_SEL) |-> ##2
        analog_ctrl.ch_port_en == ($past(pwdata[5:0], 2) < CH_FIRST_NONE) &&
        analog_ctrl.ch_fvr == ($past(pwdata[5:0], 2) == CH_FVR)) else $error("channel wrong");
    cap_value_a: assert property (s_wr(OFF_CAP_SEL) |-> ##2
        analog_ctrl.cap_pf == $past(pwdata[4:0], 2)) else $error("cap wrong");
    phase_onehot_a: assert property ($onehot0({phase_ctrl.precharge,
        phase_ctrl.acquire, phase_ctrl.convert})) else $error("phases overlap");
    check_after_conv_a: assert property (threshold_check |->
        !$past(threshold_check) &&
        ($past(phase_ctrl.convert) || $past(phase_ctrl.convert, 2))) else $error("check stray");
endmodule
bind adc_timing_input_config adc_cfg_asserts chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .accumulator_value, .lowpass_value,
    .analog_ctrl, .phase_ctrl, .conv_clk_tick, .threshold_check);

// File: bench/conv_core_model.sv
/* Behavioural converter core and computation path facing the block.
   Assumes the block's phase controls; its results feed the filter inputs. */
module conv_core_model
    import adc_cfg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire phase_ctrl_s phase_ctrl,
    output logic [15:0] accumulator_value,
    output logic [15:0] lowpass_value
);
    timeunit 1ns;
    timeprecision 1ns;
    wire busy = phase_ctrl.precharge | phase_ctrl.acquire | phase_ctrl.convert;
    // Results churn every cycle while idle, so a late sample cannot pass by luck.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accumulator_value <= 16'hace1;
            lowpass_value <= 16'h5a3c;
        end else if (!busy) begin
            accumulator_value <= {accumulator_value[14:0], accumulator_value[15] ^ busy};
            lowpass_value <= lowpass_value + 16'h1357;
        end
    end
endmodule

// File: bench/tb_top.sv
/* Self-checking bench of the converter configuration block.
   Assumes the package, the checker with its bind and the core model. */
module tb_top
    import adc_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, conv_clk_tick, threshold_check;
    logic [31:0] paddr, pwdata, prdata;
    logic [15:0] accumulator_value, lowpass_value;
    analog_ctrl_s analog_ctrl;
    phase_ctrl_s phase_ctrl;
    int n_mismatch = 0;
    int num_checks = 0;
    int n_second;
    integer seed = 32'he108;
    logic [7:0] offs [8] = '{OFF_CLK_DIV, OFF_REF_SEL, OFF_PCH_SEL, OFF_PRE_CNT, OFF_ACQ_CNT,
        OFF_CAP_SEL, OFF_RPT_THR, OFF_RPT_CNT};
    logic [7:0] masks [8] = '{8'h3f, 8'h13, 8'h3f, 8'hff, 8'hff, 8'h1f, 8'hff, 8'hff};
    logic [5:0] chs [8] = '{6'h3f, 6'h3e, 6'h3d, 6'h3c, 6'h3b, 6'h18, 6'h17, 6'h00};
    logic [7:0] pres [5] = '{8'h03, 8'h02, 8'h00, 8'h00, 8'h01};
    logic [7:0] acqs [5] = '{8'h02, 8'h00, 8'h00, 8'h05, 8'hff};
    wire [4:0] ch_seen = {analog_ctrl.ch_port_en, analog_ctrl.ch_fvr, analog_ctrl.ch_dac,
        analog_ctrl.ch_temp, analog_ctrl.ch_gnd};
    wire [3:0] ref_seen = {analog_ctrl.neg_ref_ext, analog_ctrl.pos_ref_vdd,
        analog_ctrl.pos_ref_ext, analog_ctrl.pos_ref_fvr};
    initial pclk = 1'b0;
    always #50 pclk = ~pclk;
    adc_timing_input_config uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .accumulator_value, .lowpass_value, .analog_ctrl,
        .phase_ctrl, .conv_clk_tick, .threshold_check);
    conv_core_model model (.pclk, .presetn, .phase_ctrl, .accumulator_value, .lowpass_value);
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Returns at the access edge; the next call leaves one idle cycle.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp,
        input logic eexp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        check(nm, rd, exp);
        check({nm, " error"}, {31'h0, err}, {31'h0, eexp});
    endtask
    function automatic logic [4:0] exp_ch(input logic [5:0] c);
        return {c < CH_FIRST_NONE, c == CH_FVR, c == CH_DAC, c == CH_TEMP, c == CH_GND};
    endfunction
    function automatic int exp_acq(input int pre, input int acq);
        return (acq != 0) ? acq : (pre != 0) ? int'(ACQ_ZERO_WITH_PRE) : 0;
    endfunction
    function automatic logic [31:0] exp_flt(input int m, input int sh, input logic [15:0] acc,
        input logic [15:0] lp);
        logic [15:0] f;
        f = (m == 4) ? lp : acc >> sh;
        return {24'h0, f[15:8]};
    endfunction
    task automatic run_conv(input logic [31:0] ctl, output int tp, output int ta, output int tc,
        output logic thr, output logic [15:0] acc, output logic [15:0] lp);
        int idle, ph, cur;
        logic bad;
        tp = 0;
        ta = 0;
        tc = 0;
        idle = 0;
        ph = 0;
        n_second = 0;
        bad = 1'b0;
        thr = 1'b0;
        wr(OFF_CONTROL, ctl);
        while (idle < 8) begin
            @(negedge pclk);
            cur = phase_ctrl.convert ? 3 : phase_ctrl.acquire ? 2 : phase_ctrl.precharge;
            if (phase_ctrl.second && cur == 0) ph = 0;
            bad |= cur != 0 && cur < ph;
            if (cur != 0) ph = cur;
            n_second += phase_ctrl.second;
            tp += phase_ctrl.precharge;
            ta += phase_ctrl.acquire;
            tc += phase_ctrl.convert;
            thr |= (threshold_check === 1'b1);
            if (phase_ctrl.convert) {acc, lp} = {accumulator_value, lowpass_value};
            if (tp + ta + tc > 0 && !(phase_ctrl.precharge | phase_ctrl.acquire |
                phase_ctrl.convert)) idle++;
        end
        check("phase order", {31'h0, bad}, 32'h0);
    endtask
    initial begin
        logic [31:0] v;
        logic [15:0] acc, lp;
        logic thr;
        int tp, ta, tc, d, sh;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        foreach (offs[i]) rd_chk("reset value", offs[i], 32'h0, 1'b0);
        rd_chk("idle status", OFF_STATUS, 32'h0, 1'b0);
        rd_chk("unmapped", 8'h2c, 32'h0, 1'b1);
        rd_chk("unaligned", 8'h06, 32'h0, 1'b1);
        repeat (3) foreach (offs[i]) begin
            v = $random(seed);
            wr(offs[i], v);
            rd_chk("readback", offs[i], v & {24'h0, masks[i]}, 1'b0);
        end
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 32'h0 : (i == 1) ? 32'h1f : $random(seed) & 32'h1f;
            wr(OFF_REF_SEL, {27'h0, i[2], 2'h0, i[1:0]});
            wr(OFF_PCH_SEL, {26'h0, chs[i]});
            wr(OFF_CAP_SEL, v);
            repeat (2) @(negedge pclk);
            check("ref", {28'h0, ref_seen}, {28'h0, i[2], i[1:0] == 2'h0,
                i[1:0] == 2'h2, i[1:0] == 2'h3});
            check("channel", {27'h0, ch_seen}, {27'h0, exp_ch(chs[i])});
            if (chs[i] < CH_FIRST_NONE) check("port", analog_ctrl.ch_port, chs[i]);
            check("cap", {27'h0, analog_ctrl.cap_pf}, v);
        end
        for (int i = 0; i < 5; i++) begin
            d = (i == 0) ? 63 : $random(seed) & 3;
            wr(OFF_CLK_DIV, d);
            wr(OFF_PRE_CNT, pres[i]);
            wr(OFF_ACQ_CNT, acqs[i]);
            run_conv(32'h1, tp, ta, tc, thr, acc, lp);
            check("precharge length", tp, pres[i] * 2 * (d + 1));
            check("acquire length", ta, exp_acq(pres[i], acqs[i]) * 2 * (d + 1));
            check("convert length", tc, int'(CONV_CLOCKS) * 2 * (d + 1));
        end
        wr(OFF_CLK_DIV, 32'h0);
        wr(OFF_RPT_THR, 32'h2);
        for (int m = 1; m < 5; m++) begin
            sh = {$random(seed)} % 7;
            wr(OFF_RPT_CNT, 32'h0);
            for (int r = 1; r < 3; r++) begin
                run_conv(32'(1 | m << 4 | sh << 8), tp, ta, tc, thr, acc, lp);
                check("threshold check", {31'h0, thr}, {31'h0, m > 1 && r > 1});
                rd_chk("repeat count", OFF_RPT_CNT, r, 1'b0);
                rd_chk("filter hi", OFF_FLT_HI, exp_flt(m, sh, acc, lp), 1'b0);
            end
        end
        wr(OFF_FLT_HI, ~exp_flt(4, 0, acc, lp));
        rd_chk("filter read only", OFF_FLT_HI, exp_flt(4, 0, acc, lp), 1'b0);
        run_conv(32'h3, tp, ta, tc, thr, acc, lp);
        check("double conv", tc, 4 * int'(CONV_CLOCKS));
        check("second", n_second, 2 * (1 + pres[4] + acqs[4] + int'(CONV_CLOCKS)));
        test_done();
    end
    initial begin
        repeat (60000) @(posedge pclk);
        n_mismatch++;
        test_done();
    end
endmodule
